// [hdl/spm_consts.vh]
// constants for the serial pin mux and pin state control block
//
// Contract
// RULE_01 - modes zero to three drive transmit onto data-out
// RULE_02 - mode four: data-out is SDA, clock is SCL
// RULE_03 - audio mode two routes data in and out
// RULE_04 - mode two clock pin bidirectional, audio bit clock
// RULE_05 - word-select pin only ever driven, never sampled
// RULE_06 - channel six chip selects follow master/slave
// RULE_07 - two-wire pins only pull low or release
// RULE_08 - power-on reset: wake/interrupt off, pins Hi-Z
// RULE_09 - external/internal reset: gpio holds, input zero
// RULE_10 - standby level zero holds; one floats resources
// RULE_11 - standby level one keeps interrupt pins alive
// RULE_12 - deep standby keeps wake; level one floats output
// RULE_13 - deep standby return: gpio, input zero
// RULE_14 - analog pins always Hi-Z, digital input zero
// RULE_15 - relocation select picks the numbered pin instance
// RULE_16 - standby level sampled on standby entry, held
// RULE_17 - exactly one role; unselected inputs forced inactive
`ifndef SPM_CONSTS_VH
`define SPM_CONSTS_VH
// channel operating modes
`define SPM_MODE_W 3
`define SPM_MODE_ASYNC 3'h0
`define SPM_MODE_ASYNC_MP 3'h1
`define SPM_MODE_CLKSER 3'h2
`define SPM_MODE_LIN 3'h3
`define SPM_MODE_I2C 3'h4
// device power states
`define SPM_PST_W 3
`define SPM_PST_POR 3'h0
`define SPM_PST_EXTRST 3'h1
`define SPM_PST_INTRST 3'h2
`define SPM_PST_RUN 3'h3
`define SPM_PST_STBY 3'h4
`define SPM_PST_DEEP 3'h5
`define SPM_PST_DSRET 3'h6
// pin function groups
`define SPM_GRP_W 3
`define SPM_GRP_GPIO 3'h0
`define SPM_GRP_RES 3'h1
`define SPM_GRP_EXTINT 3'h2
`define SPM_GRP_WAKE 3'h3
`define SPM_GRP_ANALOG 3'h4
// relocation select width
`define SPM_LOC_W 2
`endif

// [hdl/spm_pin_state.v]
// one pad's state gate: picks drive and input gating from power state
`timescale 1ns/100ps
`include "spm_consts.vh"
module spm_pin_state (
  input wire clk,
  input wire reset,
  input wire [2:0] power_state,
  input wire [2:0] func_group,
  input wire standby_level,
  input wire run_out,
  input wire run_oe,
  input wire pad_in,
  output wire pad_out,
  output wire pad_oe,
  output wire core_in,
  output wire wake_in
);
  // ************************************************************
  // held output state, frozen outside run; power-on reset clears the held enable
  // ************************************************************
  reg hold_out_q; // last run output value
  reg hold_oe_q; // last run output enable

  // capture pad drive while running
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      hold_out_q <= 1'b0;
      hold_oe_q <= 1'b0;
    end else begin
      if (power_state == `SPM_PST_RUN) begin
        hold_out_q <= run_out;
        hold_oe_q <= run_oe;
      end else if (power_state == `SPM_PST_POR) begin
        hold_oe_q <= 1'b0;
      end
    end
  end

  // ************************************************************
  // state table
  // ************************************************************
  reg oe_c; // resulting enable
  reg out_c; // resulting value
  reg inen_c; // digital input allowed
  reg wake_c; // wake path open
  always @* begin
    oe_c = 1'b0;
    out_c = hold_out_q;
    inen_c = 1'b0;
    wake_c = 1'b0;
    if (func_group == `SPM_GRP_ANALOG) begin
      oe_c = 1'b0; // see RULE_14
    end else begin
      case (power_state)
        `SPM_PST_POR: oe_c = 1'b0; // see RULE_08
        `SPM_PST_EXTRST, `SPM_PST_INTRST: begin
          oe_c = (func_group == `SPM_GRP_GPIO) & hold_oe_q; // see RULE_09
        end
        `SPM_PST_RUN: begin
          oe_c = run_oe;
          out_c = run_out;
          inen_c = 1'b1;
        end
        `SPM_PST_STBY: begin
          if (!standby_level || func_group == `SPM_GRP_EXTINT) begin
            oe_c = hold_oe_q; // see RULE_10
            inen_c = 1'b1; // see RULE_11
          end
        end
        `SPM_PST_DEEP: begin
          if (func_group == `SPM_GRP_WAKE) begin
            wake_c = 1'b1; // see RULE_12
            oe_c = ~standby_level & hold_oe_q; // see RULE_12
          end else if (func_group == `SPM_GRP_GPIO || !standby_level) begin
            oe_c = hold_oe_q;
          end
        end
        `SPM_PST_DSRET: begin
          oe_c = ((func_group == `SPM_GRP_WAKE) || (func_group == `SPM_GRP_EXTINT) ||
                  (func_group == `SPM_GRP_GPIO)) & hold_oe_q; // see RULE_13
        end
        default: oe_c = 1'b0;
      endcase
    end
  end

  assign pad_oe = oe_c;
  assign pad_out = out_c;
  assign core_in = pad_in & inen_c;
  assign wake_in = pad_in & wake_c;
endmodule // spm_pin_state

// [hdl/spm_serial_pin_mux.v]
// serial channel five/six pin mux with per-pad pin state control
`timescale 1ns/100ps
`include "spm_consts.vh"
module spm_serial_pin_mux #(
  parameter NPAD = 7
) (
  input wire clk,
  input wire reset,
  // device state
  input wire [2:0] power_state,
  input wire ext_reset_n,
  input wire standby_pin_level,
  input wire [6:0] pad_func_group,
  // channel five engine
  input wire [2:0] ser5_mode,
  input wire ser5_audio_en,
  input wire [1:0] ser5_ext_port_func_sel,
  input wire ser5_tx,
  input wire ser5_clk_out,
  input wire ser5_clk_oe,
  input wire ser5_sda_low,
  input wire ser5_scl_low,
  input wire ser5_ws,
  output reg ser5_rx,
  output reg ser5_clk_rx,
  output reg ser5_sda_rx,
  output reg ser5_scl_rx,
  output reg ser5_audio_rx,
  // channel six chip selects
  input wire ser6_master,
  input wire [2:0] ser6_cs_out,
  output reg [2:0] ser6_cs_rx,
  input wire ser6_ws,
  // pads: data in, data out, clock, word5, cs0/word6, cs1, cs2
  input wire [6:0] pad_in,
  output reg [6:0] pad_out,
  output reg [6:0] pad_oe,
  output reg [6:0] wake_out
);
  // ************************************************************
  // pad indices
  // ************************************************************
  localparam P_DIN = 0;
  localparam P_DOUT = 1;
  localparam P_CLK = 2;
  localparam P_WS5 = 3;
  localparam P_CS0 = 4;
  localparam P_CS1 = 5;
  localparam P_CS2 = 6;

  // ************************************************************
  // pad input synchroniser, three stages
  // ************************************************************
  reg [6:0] s1_q; // first stage, read only by s2
  reg [6:0] s2_q;
  reg [6:0] s3_q;
  reg [6:0] pin_q; // filtered level
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      s1_q <= 7'h00;
      s2_q <= 7'h00;
      s3_q <= 7'h00;
      pin_q <= 7'h00;
    end else begin
      s1_q <= pad_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      pin_q <= (s2_q & s3_q) | (pin_q & (s2_q | s3_q));
    end
  end
  reg [2:0] xrst_q; // external reset pin sync
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      xrst_q <= 3'h7;
    end else begin
      xrst_q <= {xrst_q[1:0], ext_reset_n};
    end
  end
  // effective state: a low external reset overrides run and standby
  wire [2:0] eff_state = (xrst_q[2:1] == 2'h0 && power_state != `SPM_PST_POR) ?
                         `SPM_PST_EXTRST : power_state;

  // ************************************************************
  // standby level latched at standby entry
  // ************************************************************
  reg spl_q;
  wire in_stby = (eff_state == `SPM_PST_STBY) || (eff_state == `SPM_PST_DEEP);
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      spl_q <= 1'b0;
    end else if (!in_stby) begin
      spl_q <= standby_pin_level; // see RULE_16
    end
  end

  // ************************************************************
  // functional role per pad
  // ************************************************************
  reg [6:0] fo_c; // functional out
  reg [6:0] foe_c; // functional enable
  wire loc_ok = (ser5_ext_port_func_sel == 2'h0); // see RULE_15
  wire is_i2c = (ser5_mode == `SPM_MODE_I2C);
  wire is_aud = ser5_audio_en & (ser5_mode == `SPM_MODE_CLKSER);
  always @* begin
    fo_c = 7'h00;
    foe_c = 7'h00;
    if (loc_ok) begin
      if (is_i2c) begin
        foe_c[P_DOUT] = ser5_sda_low; // see RULE_07
        foe_c[P_CLK] = ser5_scl_low; // see RULE_02
      end else if (is_aud) begin
        fo_c[P_DOUT] = ser5_tx; // see RULE_03
        foe_c[P_DOUT] = 1'b1;
        fo_c[P_CLK] = ser5_clk_out; // see RULE_04
        foe_c[P_CLK] = 1'b1;
        fo_c[P_WS5] = ser5_ws; // see RULE_05
        foe_c[P_WS5] = 1'b1;
      end else if (ser5_mode <= `SPM_MODE_LIN) begin
        fo_c[P_DOUT] = ser5_tx; // see RULE_01
        foe_c[P_DOUT] = 1'b1;
        fo_c[P_CLK] = ser5_clk_out; // see RULE_04
        foe_c[P_CLK] = ser5_clk_oe & (ser5_mode == `SPM_MODE_CLKSER);
      end
    end
    fo_c[P_CS0] = ser5_audio_en ? ser6_ws : ser6_cs_out[0];
    foe_c[P_CS0] = ser6_master | ser5_audio_en; // see RULE_06
    fo_c[P_CS1] = ser6_cs_out[1];
    foe_c[P_CS1] = ser6_master; // see RULE_06
    fo_c[P_CS2] = ser6_cs_out[2];
    foe_c[P_CS2] = ser6_master;
  end

  // ************************************************************
  // per pad state gating
  // ************************************************************
  wire [6:0] g_out;
  wire [6:0] g_oe;
  wire [6:0] g_in;
  wire [6:0] g_wk;
  genvar i;
  generate
    for (i = 0; i < NPAD; i = i + 1) begin : g_pad
      spm_pin_state u_ps (
        .clk(clk),
        .reset(reset),
        .power_state(eff_state),
        .func_group(pad_func_group[i] ? `SPM_GRP_GPIO : `SPM_GRP_RES),
        .standby_level(spl_q),
        .run_out(fo_c[i]),
        .run_oe(foe_c[i]),
        .pad_in(pin_q[i]),
        .pad_out(g_out[i]),
        .pad_oe(g_oe[i]),
        .core_in(g_in[i]),
        .wake_in(g_wk[i])
      );
    end
  endgenerate

  // ************************************************************
  // registered outputs and role inputs
  // ************************************************************
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      pad_out <= 7'h00;
      pad_oe <= 7'h00;
      wake_out <= 7'h00;
      ser5_rx <= 1'b1;
      ser5_clk_rx <= 1'b0;
      ser5_sda_rx <= 1'b1;
      ser5_scl_rx <= 1'b1;
      ser5_audio_rx <= 1'b0;
      ser6_cs_rx <= 3'h0;
    end else begin
      // i2c pads never drive a one
      pad_out <= is_i2c ? (g_out & ~7'h06) : g_out; // see RULE_07
      pad_oe <= g_oe;
      wake_out <= g_wk;
      // unselected roles see idle levels
      ser5_rx <= (!is_i2c && !is_aud) ? g_in[P_DIN] : 1'b1; // see RULE_17
      ser5_clk_rx <= (ser5_mode == `SPM_MODE_CLKSER && !is_aud) ? g_in[P_CLK] : 1'b0;
      ser5_sda_rx <= is_i2c ? g_in[P_DOUT] : 1'b1; // see RULE_17
      ser5_scl_rx <= is_i2c ? g_in[P_CLK] : 1'b1;
      ser5_audio_rx <= is_aud ? g_in[P_DIN] : 1'b0; // see RULE_03
      ser6_cs_rx <= ser6_master ? 3'h0 : {g_in[P_CS2], g_in[P_CS1],
                    ser5_audio_en ? 1'b0 : g_in[P_CS0]}; // see RULE_06
    end
  end
endmodule // spm_serial_pin_mux

// [testbench/spm_serial_pin_mux_asserts.sv]
// concurrent checks on the serial pin mux ports
`timescale 1ns/100ps
`include "spm_consts.vh"
module spm_serial_pin_mux_asserts #(
  parameter NPAD = 7
) (
  input wire clk,
  input wire reset,
  input wire [2:0] power_state,
  input wire ext_reset_n,
  input wire standby_pin_level,
  input wire [6:0] pad_func_group,
  input wire [2:0] ser5_mode,
  input wire ser5_audio_en,
  input wire [1:0] ser5_ext_port_func_sel,
  input wire ser5_tx,
  input wire ser5_sda_low,
  input wire ser5_ws,
  input wire ser6_master,
  input wire [2:0] ser6_cs_out,
  input wire [6:0] pad_out,
  input wire [6:0] pad_oe,
  input wire [6:0] wake_out
);
  // ***********************************
  // helper state and checks
  // ***********************************
  reg [3:0] ext_q; // reset pin seen high over the synchroniser depth
  reg run_q; // run state one edge ago
  reg run5_q; // run state with channel five pads served
  wire run_now = (power_state == `SPM_PST_RUN) && (&ext_q);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // track run so checks start only on settled states
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      ext_q <= 4'h0;
      run_q <= 1'b0;
      run5_q <= 1'b0;
    end else begin
      ext_q <= {ext_q[2:0], ext_reset_n};
      run_q <= run_now;
      run5_q <= run_now && (ser5_ext_port_func_sel == 2'h0);
    end
  end
  a_tx_route: assert property (run5_q && $past(ser5_mode) <= 3'h3 |->
    pad_oe[1] && pad_out[1] == $past(ser5_tx)) else $error("tx not on data out");
  a_i2c_pull: assert property (run5_q && $past(ser5_mode) == `SPM_MODE_I2C |->
    pad_oe[1] == $past(ser5_sda_low)) else $error("sda pull wrong");
  a_i2c_no_high: assert property (run5_q && $past(ser5_mode) == `SPM_MODE_I2C |->
    pad_out[2:1] == 2'h0) else $error("two-wire pad driven high");
  a_ws_drive: assert property (run5_q && $past(ser5_mode == 3'h2 && ser5_audio_en) |->
    pad_oe[3] && pad_out[3] == $past(ser5_ws)) else $error("word select not driven");
  a_cs_master: assert property (run_q && $past(ser6_master) |->
    pad_oe[6:5] == 2'h3 && pad_out[6:5] == $past(ser6_cs_out[2:1])) else $error("cs out wrong");
  a_cs_slave: assert property (run_q && !$past(ser6_master) |->
    pad_oe[6:5] == 2'h0) else $error("slave cs driven");
  a_por_float: assert property ($past(power_state) == `SPM_PST_POR |->
    pad_oe == 7'h00 && wake_out == 7'h00) else $error("pads active in power-on reset");
  a_stby_float: assert property ((run_now && standby_pin_level && pad_func_group == 7'h00)
    ##1 (power_state == `SPM_PST_STBY && pad_func_group == 7'h00) [*2] |-> pad_oe == 7'h00)
    else $error("resource pad driven in standby");
  a_stby_hold: assert property ((run_now && !standby_pin_level)
    ##1 (power_state == `SPM_PST_STBY) [*2] |-> $stable(pad_oe) && $stable(pad_out))
    else $error("pad state not held in standby");
  a_reloc_idle: assert property (run_q && $past(ser5_ext_port_func_sel) != 2'h0 |->
    pad_oe[3:0] == 4'h0) else $error("relocated pads still driven");
  c_i2c: cover property (run5_q && ser5_mode == `SPM_MODE_I2C && ser5_sda_low);
  c_audio: cover property (run5_q && ser5_mode == 3'h2 && ser5_audio_en);
  c_stby: cover property (power_state == `SPM_PST_STBY && standby_pin_level);
endmodule // spm_serial_pin_mux_asserts
bind spm_serial_pin_mux spm_serial_pin_mux_asserts #(.NPAD(NPAD)) u_chk (.clk(clk), .reset(reset),
  .power_state(power_state), .ext_reset_n(ext_reset_n), .standby_pin_level(standby_pin_level),
  .pad_func_group(pad_func_group), .ser5_mode(ser5_mode), .ser5_audio_en(ser5_audio_en),
  .ser5_ext_port_func_sel(ser5_ext_port_func_sel), .ser5_tx(ser5_tx), .ser5_sda_low(ser5_sda_low),
  .ser5_ws(ser5_ws), .ser6_master(ser6_master), .ser6_cs_out(ser6_cs_out), .pad_out(pad_out),
  .pad_oe(pad_oe), .wake_out(wake_out));

// [testbench/spm_pin_peer.sv]
// far-side model: serial devices on the seven pads, pull-ups on the two-wire pads
`timescale 1ns/100ps
module spm_pin_peer (
  input wire clk,
  input wire [6:0] pad_out,
  input wire [6:0] pad_oe,
  input wire [6:0] peer_drive,
  input wire [6:0] peer_oe,
  output reg [6:0] pad_in
);
  reg flip_q = 1'b0; // changing level for undriven pads without a pull
  integer i;
  // flip each cycle so a floating pad never looks like a held value
  always @(posedge clk) begin
    flip_q <= ~flip_q;
  end
  // resolve every pad from both parties' enables
  always @* begin
    for (i = 0; i < 7; i = i + 1) begin
      if (i == 1 || i == 2) begin
        // wired low on the two-wire pads, pulled up when nobody pulls
        pad_in[i] = !((pad_oe[i] && !pad_out[i]) || (peer_oe[i] && !peer_drive[i]));
      end else if (pad_oe[i]) begin
        pad_in[i] = pad_out[i];
      end else if (peer_oe[i]) begin
        pad_in[i] = peer_drive[i];
      end else begin
        pad_in[i] = flip_q ^ i[0];
      end
    end
  end
endmodule // spm_pin_peer

// [testbench/spm_serial_pin_mux_tb.sv]
// self-checking bench for the serial pin mux and pin state control
`timescale 1ns/100ps
`include "spm_consts.vh"
`define CHK(nm, ex, sn) begin compares = compares + 1; if ((sn) !== (ex)) begin \
  miscompares = miscompares + 1; $display("unexpected %s exp %h saw %h", nm, ex, sn); end end
module spm_serial_pin_mux_tb;
  reg clk, reset, ext_reset_n, standby_pin_level, ser5_audio_en, ser5_tx, ser5_clk_out;
  reg ser5_clk_oe, ser5_sda_low, ser5_scl_low, ser5_ws, ser6_master, ser6_ws;
  reg [2:0] power_state, ser5_mode, ser6_cs_out;
  reg [1:0] ser5_ext_port_func_sel;
  reg [6:0] pad_func_group, peer_drive, peer_oe;
  wire [6:0] pad_in, pad_out, pad_oe, wake_out;
  wire [2:0] ser6_cs_rx;
  wire ser5_rx, ser5_clk_rx, ser5_sda_rx, ser5_scl_rx, ser5_audio_rx;
  reg [31:0] seed;
  reg [13:0] saved;
  integer compares, miscompares, cyc, i;
  spm_serial_pin_mux dut (.clk(clk), .reset(reset), .power_state(power_state),
    .ext_reset_n(ext_reset_n), .standby_pin_level(standby_pin_level),
    .pad_func_group(pad_func_group), .ser5_mode(ser5_mode), .ser5_audio_en(ser5_audio_en),
    .ser5_ext_port_func_sel(ser5_ext_port_func_sel), .ser5_tx(ser5_tx),
    .ser5_clk_out(ser5_clk_out), .ser5_clk_oe(ser5_clk_oe), .ser5_sda_low(ser5_sda_low),
    .ser5_scl_low(ser5_scl_low), .ser5_ws(ser5_ws), .ser5_rx(ser5_rx), .ser5_clk_rx(ser5_clk_rx),
    .ser5_sda_rx(ser5_sda_rx), .ser5_scl_rx(ser5_scl_rx), .ser5_audio_rx(ser5_audio_rx),
    .ser6_master(ser6_master), .ser6_cs_out(ser6_cs_out), .ser6_cs_rx(ser6_cs_rx),
    .ser6_ws(ser6_ws), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .wake_out(wake_out));
  spm_pin_peer u_peer (.clk(clk), .pad_out(pad_out), .pad_oe(pad_oe), .peer_drive(peer_drive),
    .peer_oe(peer_oe), .pad_in(pad_in));
  // ***********************************
  // helpers
  // ***********************************
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // data-out pad enable and level for a channel mode
  function [1:0] exp_pad1(input [2:0] m, input tx, input sda);
    exp_pad1 = (m == `SPM_MODE_I2C) ? {sda, 1'b0} : {1'b1, tx};
  endfunction
  task step(input integer n);
    repeat (n) @(negedge clk);
  endtask
  task wrap_up;
    begin
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  // free-running clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // hang guard
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      miscompares = miscompares + 1;
      wrap_up;
    end
  end
  // ***********************************
  // main sequence
  // ***********************************
  initial begin
    {compares, miscompares, cyc} = 0;
    seed = 32'h651C;
    {reset, ext_reset_n, power_state} = {2'h3, `SPM_PST_RUN};
    {standby_pin_level, ser5_mode, ser5_audio_en, ser5_tx, ser5_clk_out, ser5_clk_oe} = 8'h0;
    {ser5_sda_low, ser5_scl_low, ser5_ws, ser6_master, ser6_ws, ser6_cs_out} = 8'h0;
    {ser5_ext_port_func_sel, pad_func_group, peer_drive, peer_oe} = 23'h0;
    step(2);
    reset = 1'b0;
    step(6);
    // random traffic, first five passes walk every mode
    for (i = 0; i < 30; i = i + 1) begin
      seed = lfsr(seed);
      ser5_mode = (i < 5) ? i : seed[2:0] % 5;
      {ser5_audio_en, ser5_tx, ser5_sda_low, ser5_scl_low, ser5_ws, ser6_master} = seed[8:3];
      {ser6_cs_out, ser5_clk_oe, ser5_clk_out, ser6_ws} = seed[14:9];
      peer_drive = {seed[17:15], 3'h0, seed[18]};
      peer_oe = {{3{~ser6_master}}, 1'b0, (ser5_mode == 3'h4) ? seed[20:19] : 2'h0, 1'b1};
      step(8);
      if (ser5_mode == `SPM_MODE_I2C) begin
        `CHK("pad1", exp_pad1(ser5_mode, ser5_tx, ser5_sda_low), {pad_oe[1], pad_out[1]})
        `CHK("sda_rx", ~(ser5_sda_low | seed[19]), ser5_sda_rx)
        `CHK("rx_idle", 1'b1, ser5_rx)
        `CHK("scl_rx", ~(ser5_scl_low | seed[20]), ser5_scl_rx)
      end else begin
        `CHK("pad1", exp_pad1(ser5_mode, ser5_tx, ser5_sda_low), {pad_oe[1], pad_out[1]})
        if (!(ser5_mode == 3'h2 && ser5_audio_en)) `CHK("rx", seed[18], ser5_rx)
      end
      if (ser5_mode == 3'h2 && ser5_audio_en) begin
        `CHK("audio_rx", seed[18], ser5_audio_rx)
        `CHK("ws_pad", {1'b1, ser5_ws}, {pad_oe[3], pad_out[3]})
      end else if (ser5_mode == 3'h2) begin
        `CHK("clk_oe", ser5_clk_oe, pad_oe[2])
      end
      if (ser6_master) `CHK("cs_pads", {2'h3, ser6_cs_out[2:1]}, {pad_oe[6:5], pad_out[6:5]})
      else `CHK("cs_rx", seed[17:16], ser6_cs_rx[2:1])
    end
    ser5_ext_port_func_sel = 2'h1;
    step(3);
    `CHK("reloc_oe", 4'h0, pad_oe[3:0])
    {ser5_ext_port_func_sel, ser5_mode, pad_func_group, ext_reset_n} = {5'h0, 7'h7F, 1'b0};
    step(5);
    saved = {pad_oe, pad_out};
    ser5_tx = ~ser5_tx;
    step(4);
    `CHK("extrst_hold", saved[6:0], pad_out)
    {ext_reset_n, pad_func_group, standby_pin_level} = {1'b1, 7'h00, 1'b1};
    step(8);
    power_state = `SPM_PST_STBY;
    step(3);
    `CHK("stby_oe", 7'h00, pad_oe)
    power_state = `SPM_PST_RUN;
    step(3);
    power_state = `SPM_PST_DEEP;
    step(3);
    `CHK("deep_oe", 7'h00, pad_oe)
    {power_state, standby_pin_level} = {`SPM_PST_RUN, 1'b0};
    step(4);
    saved = {pad_oe, pad_out};
    power_state = `SPM_PST_STBY;
    ser5_tx = ~ser5_tx;
    step(3);
    `CHK("stby_hold", saved, {pad_oe, pad_out})
    power_state = `SPM_PST_POR;
    step(3);
    `CHK("por_pads", 14'h0, {pad_oe, wake_out})
    wrap_up;
  end
endmodule // spm_serial_pin_mux_tb
